/* File: core/lvdc_pkg.sv */
// package: register map, field positions and reset values of the low-voltage detector control
package lvdc_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] LVDC_CTRL_ADDR   = 4'h0;
    localparam logic [3:0] LVDC_LEVEL_ADDR  = 4'h4;
    localparam logic [3:0] LVDC_STATUS_ADDR = 4'h8;
    localparam logic [3:0] LVDC_MASK_ADDR   = 4'hC;
    // detector_control_reg fields
    localparam int LVDC_CTRL_ENABLE_BIT = 7;  // detector_enable
    localparam int LVDC_CTRL_SOURCE_BIT = 2;  // 1: external_detect_input monitored
    localparam int LVDC_CTRL_RESET_BIT  = 1;  // reset_mode_select
    localparam int LVDC_CTRL_MASK_BIT   = 0;  // detector_interrupt_mask
    localparam logic [7:0] LVDC_CTRL_WMASK  = 8'h87;
    localparam logic [7:0] LVDC_CTRL_RESET  = 8'h01;
    // detection_level_select_reg: low four bits hold the level code
    localparam int LVDC_LEVEL_WIDTH = 4;
    localparam logic [3:0] LVDC_LEVEL_RESET = 4'h0;
    // interrupt status / mask layout
    localparam int LVDC_EV_DETECT = 0;  // monitored voltage fell below threshold
    localparam int LVDC_EV_RESET  = 1;  // internal reset requested
    localparam int LVDC_EV_WIDTH  = 2;
    localparam logic [1:0] LVDC_EV_RESET_VAL = 2'h0;
endpackage

/* File: core/lvdc_sync.sv */
// two-flop synchroniser for level inputs from the analog comparators
`timescale 1ns/1ps
module lvdc_sync #(
    parameter int WIDTH = 2
) (
    // clock
    input  wire logic             clk_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;

    // first stage read only by the second
    always_ff @(posedge clk_i) begin
        stage1 <= async_i;
        sync_o <= stage1;
    end
endmodule

/* File: core/lvdc_top.sv */
// low-voltage detector control block with classic wishbone register slave
//
// Function
// RULE_01 - writing 00H to control stops detector
// RULE_02 - clearing enable alone stops, others kept
// RULE_03 - software keeps level bits 4-7 zero
// RULE_04 - software changes level only while stopped
// RULE_05 - external input uses fixed threshold, level ignored
// RULE_06 - unmasked interrupt may fire right after enable
// RULE_07 - no reset when voltage above threshold
// RULE_08 - own internal reset leaves detector un-reset
// RULE_09 - reset mode asserts reset while voltage low
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module lvdc_top
    import lvdc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    // analog comparator results (asynchronous, high = below threshold)
    input  wire logic        supply_below_i,
    input  wire logic        external_below_i,
    // analog front end control
    output logic             detector_enable_o,
    output logic             external_select_o,
    output logic [3:0]       level_select_o,
    // system side
    output logic             internal_reset_o,
    output logic             irq_o
);
    logic [7:0]               ctrl;
    logic [3:0]               level;
    logic [LVDC_EV_WIDTH-1:0] status;
    logic [LVDC_EV_WIDTH-1:0] mask;
    logic [1:0]               cmp_sync;
    logic                     below_q;
    logic                     reset_q;

    lvdc_sync #(.WIDTH(2)) u_sync (
        .clk_i   (clk_i),
        .async_i ({external_below_i, supply_below_i}),
        .sync_o  (cmp_sync)
    );

    // bus decode
    wire req        = cyc_i & stb_i & ~ack_o & ~err_o;
    wire hit_ctrl   = adr_i == LVDC_CTRL_ADDR;
    wire hit_level  = adr_i == LVDC_LEVEL_ADDR;
    wire hit_status = adr_i == LVDC_STATUS_ADDR;
    wire hit_mask   = adr_i == LVDC_MASK_ADDR;
    wire mapped     = hit_ctrl | hit_level | hit_status | hit_mask;
    wire wr_lane0   = req & we_i & sel_i[0] & mapped;

    // detector control fields
    wire enable     = ctrl[LVDC_CTRL_ENABLE_BIT];
    wire ext_sel    = ctrl[LVDC_CTRL_SOURCE_BIT];
    wire reset_mode = ctrl[LVDC_CTRL_RESET_BIT];
    wire int_masked = ctrl[LVDC_CTRL_MASK_BIT];
    // source choice: external pin ignores the level code entirely
    wire below      = enable & (ext_sel ? cmp_sync[1] : cmp_sync[0]); // [RULE_05]
    wire next_reset = enable & reset_mode & below; // [RULE_07] [RULE_09]
    wire below_rise = below & ~below_q;
    wire [LVDC_EV_WIDTH-1:0] events = {next_reset & ~reset_q,
                                       below_rise & ~reset_mode & ~int_masked};

    // control registers: only rst_i clears them, never internal_reset_o [RULE_08]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl  <= LVDC_CTRL_RESET;
            level <= LVDC_LEVEL_RESET;
            mask  <= LVDC_EV_RESET_VAL;
        end else if (wr_lane0) begin
            // full byte write; 00H clears enable and all modes [RULE_01] [RULE_02]
            if (hit_ctrl) begin
                ctrl <= dat_i[7:0] & LVDC_CTRL_WMASK;
            end
            // upper nibble discarded, reads back zero [RULE_03]
            // writes while running are taken as they come; keeping the level
            // still during operation is left to software, no lockout here
            if (hit_level) begin
                level <= dat_i[LVDC_LEVEL_WIDTH-1:0];
            end
            if (hit_mask) begin
                mask <= dat_i[LVDC_EV_WIDTH-1:0];
            end
        end
    end

    // sticky status; a new event wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= LVDC_EV_RESET_VAL;
        end else begin
            status <= (status & ~(wr_lane0 & hit_status ? dat_i[LVDC_EV_WIDTH-1:0]
                                                        : {LVDC_EV_WIDTH{1'b0}})) | events;
        end
    end

    // detection edge and reset request registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            below_q <= 1'b0;
            reset_q <= 1'b0;
        end else begin
            below_q <= below;
            reset_q <= next_reset;
        end
    end

    // read mux
    wire [31:0] rd_data = hit_ctrl   ? {24'h000000, ctrl}
                        : hit_level  ? {28'h0000000, level}
                        : hit_status ? {30'h00000000, status}
                        : hit_mask   ? {30'h00000000, mask}
                        : 32'h00000000;

    // one-cycle answer; unmapped addresses take err
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req & mapped;
            err_o <= req & ~mapped;
            dat_o <= (req & ~we_i) ? rd_data : 32'h00000000;
        end
    end

    // outputs; an unmasked detect may fire right after enable [RULE_06]
    assign irq_o             = |(status & mask);
    assign internal_reset_o  = reset_q;
    assign detector_enable_o = enable;
    assign external_select_o = ext_sel;
    assign level_select_o    = level;

    // assertions
    a_reset_follows_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
        (enable && reset_mode && below) |=> internal_reset_o)
        else $error("internal reset missing while voltage low in reset mode");
    a_no_reset_high: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_07]
        !(enable && reset_mode && below) |=> !internal_reset_o)
        else $error("internal reset raised while voltage above threshold");
    a_zero_write_stops: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
        (wr_lane0 && hit_ctrl && dat_i[7:0] == 8'h00) |=> (ctrl == 8'h00 && !detector_enable_o))
        else $error("zero control write did not stop detector");
    a_enable_clear_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_02]
        (wr_lane0 && hit_ctrl && !dat_i[LVDC_CTRL_ENABLE_BIT])
        |=> (!enable && ctrl[2:0] == $past(dat_i[2:0])))
        else $error("enable clear lost other control bits");
    a_ext_ignores_level: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
        (enable && ext_sel) |-> (below == cmp_sync[1]))
        else $error("external source did not use its own comparator");
    a_reset_keeps_ctrl: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_08]
        (internal_reset_o && !wr_lane0) |=> $stable(ctrl) && $stable(level))
        else $error("own internal reset disturbed detector settings");
    a_detect_irq: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        (below_rise && !reset_mode && !int_masked && mask[LVDC_EV_DETECT]) |=> irq_o)
        else $error("unmasked detection did not raise interrupt");
    a_level_nibble: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        (wr_lane0 && hit_level) |=> (level == $past(dat_i[3:0])))
        else $error("level select write not stored");
    a_level_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_03]
        (req && !we_i && hit_level) |=> (dat_o[31:4] == 28'h0000000))
        else $error("level select upper bits read back nonzero");

    // detector behaviour beyond the rule checks above
    a_stop_no_reset: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_01]
        !enable |=> !internal_reset_o)
        else $error("internal reset raised while detector stopped");
    a_supply_source: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_05]
        (enable && !ext_sel) |-> (below == cmp_sync[0]))
        else $error("supply source did not use supply comparator");
    a_mask_blocks_detect: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        int_masked |-> !events[LVDC_EV_DETECT])
        else $error("masked detector still raised a detect event");
    a_irq_needs_mask: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_06]
        (mask == {LVDC_EV_WIDTH{1'b0}}) |-> !irq_o)
        else $error("interrupt raised with every source masked");
    a_reset_mode_no_detect: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
        reset_mode |-> !events[LVDC_EV_DETECT])
        else $error("reset mode raised a detect interrupt event");
    a_reset_event: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE_09]
        (next_reset && !reset_q) |=> status[LVDC_EV_RESET])
        else $error("internal reset not recorded in status");

    // sticky status: holds until a write of one, and a new event wins
    a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (status[0] && !(wr_lane0 && hit_status && dat_i[0])) |=> status[0])
        else $error("detect status bit lost without a clear");
    a_status_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_status && dat_i[0] && !events[0]) |=> !status[0])
        else $error("detect status bit not cleared by write of one");

    // bus handshake: registered single-cycle answers
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_mapped: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && mapped) |=> (ack_o && !err_o))
        else $error("mapped request not acknowledged");
    a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !mapped) |=> (err_o && !ack_o))
        else $error("unmapped request not answered with err");
    a_read_zero_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack_o |-> (dat_o == 32'h00000000))
        else $error("read data nonzero outside an acknowledge");
    a_sel_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && we_i && !sel_i[0] && hit_ctrl) |=> $stable(ctrl))
        else $error("control changed by write without lane zero");
endmodule

/* File: tb/tb.sv */
// self-checking bench for the low-voltage detector control block
`timescale 1ns/1ps
module tb;
    import lvdc_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic supply_below_i = 0, external_below_i = 0, ack_o, err_o;
    logic detector_enable_o, external_select_o, internal_reset_o, irq_o;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0, level_select_o;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    int n_errors = 0, cmp_count = 0;
    lvdc_top i_dut (.*);
    // 125 MHz clock
    always #4 clk_i = ~clk_i;
    // one classic cycle; values read right after an edge are the pre-edge ones
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
        do begin @(posedge clk_i); n++; end while (!(ack_o === 1'b1 || err_o === 1'b1) && n < 20);
        q = (err_o === 1'b1) ? 32'hEEEE_EEEE : dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w8(input int n); repeat (n) @(posedge clk_i); endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // reset values and the unmapped hole
    task automatic t_reset;
        bus(0, LVDC_CTRL_ADDR, 0); chk(q, 32'h01);
        bus(0, LVDC_STATUS_ADDR, 0); chk(q, 32'h00);
        bus(0, 4'h2, 0); chk(q, 32'hEEEE_EEEE);
    endtask
    // byte write of zero stops the detector
    task automatic t_stop_byte;
        bus(1, LVDC_CTRL_ADDR, 32'h87); chk(detector_enable_o, 1'b1);
        bus(1, LVDC_CTRL_ADDR, 32'h00); chk(detector_enable_o, 1'b0);
        bus(0, LVDC_CTRL_ADDR, 0); chk(q, 32'h00);
    endtask
    // only the enable bit cleared, the rest kept
    task automatic t_stop_bit;
        bus(1, LVDC_LEVEL_ADDR, 32'h3); bus(1, LVDC_CTRL_ADDR, 32'h86);
        bus(1, LVDC_CTRL_ADDR, 32'h06); chk(detector_enable_o, 1'b0);
        bus(0, LVDC_CTRL_ADDR, 0); chk(q, 32'h06);
        chk(level_select_o, 4'h3);
        bus(1, LVDC_CTRL_ADDR, 32'h00);
    endtask
    // unmasked detection raises the line within six cycles, mask and clear drop it
    task automatic t_irq;
        bus(1, LVDC_MASK_ADDR, 32'h1); bus(1, LVDC_CTRL_ADDR, 32'h80);
        supply_below_i <= 1'b1; w8(6); chk(irq_o, 1'b1);
        bus(1, LVDC_MASK_ADDR, 32'h0); chk(irq_o, 1'b0);
        supply_below_i <= 1'b0; w8(6); bus(1, LVDC_STATUS_ADDR, 32'h1);
        bus(0, LVDC_STATUS_ADDR, 0); chk(q, 32'h0);
        bus(1, LVDC_CTRL_ADDR, 32'h00);
    endtask
    // external pin monitored: supply level and level code play no part
    task automatic t_ext;
        bus(1, LVDC_LEVEL_ADDR, 32'hF); bus(1, LVDC_CTRL_ADDR, 32'h84);
        chk(external_select_o, 1'b1); supply_below_i <= 1'b1; w8(6);
        bus(0, LVDC_STATUS_ADDR, 0); chk(q, 32'h0);
        supply_below_i <= 1'b0; external_below_i <= 1'b1; w8(6);
        bus(0, LVDC_STATUS_ADDR, 0); chk(q, 32'h1);
        external_below_i <= 1'b0; bus(1, LVDC_CTRL_ADDR, 32'h00);
        w8(4); bus(1, LVDC_STATUS_ADDR, 32'h3);
    endtask
    // reset mode: quiet while above, asserted while below, settings survive
    task automatic t_rmode;
        bus(1, LVDC_CTRL_ADDR, 32'h82); w8(5); chk(internal_reset_o, 1'b0);
        supply_below_i <= 1'b1; w8(5); chk(internal_reset_o, 1'b1);
        bus(0, LVDC_CTRL_ADDR, 0); chk(q, 32'h82);
        bus(0, LVDC_STATUS_ADDR, 0); chk(q, 32'h2);
        supply_below_i <= 1'b0; w8(5); chk(internal_reset_o, 1'b0);
    endtask
    // watchdog, far beyond the roughly 125 cycles the tests need
    initial begin
        #20000;
        n_errors++;
        stop_test;
    end
    initial begin
        w8(2); rst_i <= 1'b0; @(posedge clk_i);
        t_reset; t_stop_byte; t_stop_bit; t_irq; t_ext; t_rmode;
        stop_test;
    end
endmodule
